// >>> design/fsps_sequencer.sv
// Flash self-program sequencer top
`default_nettype none
module fsps_sequencer #(
    parameter int TICK_CYC = fsps_pkg::TICK_CYCLES,
    parameter int PROG_TICK_COUNT = fsps_pkg::PROG_TICKS,
    parameter logic [fsps_pkg::PAGE_BITS-1:0] NCR_PAGE = fsps_pkg::NCR_FIRST_PAGE
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic csr_wr,
    input wire logic [7:0] csr_wdata,
    input wire logic spm_exec,
    input wire logic lpm_exec,
    input wire logic [15:0] z_addr,
    input wire logic [15:0] spm_data,
    input wire logic eeprom_program_enable,
    input wire logic [7:0] low_fuse_byte,
    input wire logic [7:0] high_fuse_byte,
    input wire logic [3:0] extended_fuse_byte,
    input wire logic [fsps_pkg::WORD_BITS-1:0] prog_word_idx,
    output logic [7:0] self_program_control_status,
    output logic [7:0] lpm_data,
    output logic lpm_valid,
    output logic spm_irq,
    output logic cpu_halt,
    output logic app_section_busy,
    output logic flash_erase_go,
    output logic flash_write_go,
    output logic [fsps_pkg::PAGE_BITS-1:0] flash_page,
    output logic [15:0] prog_word,
    output logic [5:0] lock_bits
);
    import fsps_pkg::*;

    fsps_state_t state_r;
    logic [4:0] cmd_r;
    logic [2:0] spm_win_r;
    logic [2:0] lpm_win_r;
    logic ie_r;
    logic [PAGE_BITS-1:0] page_r;
    logic ncr_r;
    logic [5:0] lock_data_r;
    logic [15:0] tick_cnt_r;
    logic [15:0] prog_cnt_r;
    logic eeprom_d_r;
    logic app_busy_r;
    logic [5:0] lock_r;
    logic arm_go;
    logic reen_go;
    logic spm_go;
    logic lpm_go;
    logic tick;
    logic prog_done;
    logic buf_clear;
    logic buf_any;
    logic [15:0] buf_rd;
    logic [PAGE_BITS-1:0] z_page;

    assign z_page = z_addr[PAGE_LSB +: PAGE_BITS];
    // Arming ignored while an EEPROM write runs or another operation is active
    assign arm_go = csr_wr && csr_wdata[CSR_STORE_EN_BIT] && (state_r == FSPS_IDLE)
        && !eeprom_program_enable && (csr_wdata[4:0] != CMD_REEN)
        && (fsps_is_timed(csr_wdata[4:0]) || csr_wdata[4:0] == CMD_LOAD);
    assign reen_go = csr_wr && (csr_wdata[4:0] == CMD_REEN) && (state_r == FSPS_IDLE)
        && !eeprom_program_enable;
    assign spm_go = (state_r == FSPS_ARMED) && spm_exec && !eeprom_program_enable;
    assign lpm_go = (state_r == FSPS_ARMED) && lpm_exec && (cmd_r == CMD_LOCK)
        && (lpm_win_r != 3'h0) && !eeprom_program_enable;
    assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));
    assign prog_done = (state_r == FSPS_RUN) && tick
        && (prog_cnt_r == 16'(PROG_TICK_COUNT - 1));
    assign buf_clear = reen_go || (prog_done && cmd_r == CMD_WRITE)
        || (eeprom_program_enable && !eeprom_d_r);

    // Sequence state
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= FSPS_IDLE;
        end
        else
        begin
            case (state_r)
                FSPS_IDLE:
                begin
                    if (arm_go)
                    begin
                        state_r <= FSPS_ARMED;
                    end
                end
                FSPS_ARMED:
                begin
                    if (spm_go)
                    begin
                        state_r <= fsps_is_timed(cmd_r) ? FSPS_RUN : FSPS_IDLE;
                    end
                    else if (lpm_go || spm_win_r == 3'h1)
                    begin
                        state_r <= FSPS_IDLE;
                    end
                end
                FSPS_RUN:
                begin
                    if (prog_done)
                    begin
                        state_r <= FSPS_IDLE;
                    end
                end
                default:
                begin
                    state_r <= FSPS_IDLE;
                end
            endcase
        end
    end

    // Command, windows and interrupt enable
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_r <= CSR_RESET[4:0];
            spm_win_r <= 3'h0;
            lpm_win_r <= 3'h0;
            ie_r <= CSR_RESET[CSR_IE_BIT];
        end
        else
        begin
            if (csr_wr)
            begin
                ie_r <= csr_wdata[CSR_IE_BIT];
            end
            if (arm_go)
            begin
                cmd_r <= csr_wdata[4:0];
                spm_win_r <= 3'(SPM_WINDOW);
                lpm_win_r <= 3'(LPM_WINDOW);
            end
            else
            begin
                if (spm_win_r != 3'h0)
                begin
                    spm_win_r <= spm_win_r - 3'h1;
                end
                if (lpm_win_r != 3'h0)
                begin
                    lpm_win_r <= lpm_win_r - 3'h1;
                end
            end
        end
    end

    // Latched target of a started operation
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            page_r <= '0;
            ncr_r <= 1'b0;
            lock_data_r <= LOCK_RESET;
        end
        else if (spm_go)
        begin
            page_r <= z_page;
            ncr_r <= (z_page >= NCR_PAGE);
            lock_data_r <= spm_data[5:0];
        end
    end

    // Programming timer on a microsecond tick
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_cnt_r <= 16'h0000;
            prog_cnt_r <= 16'h0000;
        end
        else if (state_r != FSPS_RUN)
        begin
            tick_cnt_r <= 16'h0000;
            prog_cnt_r <= 16'h0000;
        end
        else if (tick)
        begin
            tick_cnt_r <= 16'h0000;
            prog_cnt_r <= prog_cnt_r + 16'h0001;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
        end
    end

    // Section busy, CPU halt and lock bits
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            app_busy_r <= 1'b0;
            cpu_halt <= 1'b0;
            lock_r <= LOCK_RESET;
        end
        else
        begin
            if (spm_go && fsps_is_array(cmd_r))
            begin
                app_busy_r <= 1'b1;
            end
            else if (reen_go)
            begin
                app_busy_r <= 1'b0;
            end
            if (spm_go && fsps_is_array(cmd_r) && z_page >= NCR_PAGE)
            begin
                cpu_halt <= 1'b1;
            end
            else if (prog_done)
            begin
                cpu_halt <= 1'b0;
            end
            if (prog_done && cmd_r == CMD_LOCK)
            begin
                lock_r <= lock_r & lock_data_r;
            end
        end
    end

    // Fuse and lock reads
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lpm_valid <= 1'b0;
            lpm_data <= READ_FILL;
        end
        else
        begin
            lpm_valid <= lpm_go;
            if (lpm_go)
            begin
                case (z_addr)
                    Z_FUSE_LOW: lpm_data <= low_fuse_byte;
                    Z_LOCK: lpm_data <= {READ_FILL[7:6], lock_r};
                    Z_FUSE_EXT: lpm_data <= {READ_FILL[7:4], extended_fuse_byte};
                    Z_FUSE_HIGH: lpm_data <= high_fuse_byte;
                    default: lpm_data <= READ_FILL;
                endcase
            end
        end
    end

    // Registered status and strobes
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            self_program_control_status <= CSR_RESET;
            spm_irq <= 1'b0;
            app_section_busy <= 1'b0;
            flash_erase_go <= 1'b0;
            flash_write_go <= 1'b0;
            flash_page <= '0;
            prog_word <= 16'h0000;
            lock_bits <= LOCK_RESET;
            eeprom_d_r <= 1'b0;
        end
        else
        begin
            self_program_control_status <= {ie_r, app_busy_r, 1'b0,
                (state_r != FSPS_IDLE) ? cmd_r[4:1] : 4'h0, state_r != FSPS_IDLE};
            spm_irq <= ie_r && (state_r == FSPS_IDLE);
            app_section_busy <= app_busy_r;
            flash_erase_go <= spm_go && cmd_r == CMD_ERASE;
            flash_write_go <= spm_go && cmd_r == CMD_WRITE;
            flash_page <= page_r;
            prog_word <= buf_rd;
            lock_bits <= lock_r;
            eeprom_d_r <= eeprom_program_enable;
        end
    end

    fsps_page_buffer #(
        .WORDS(32),
        .IDX_BITS(WORD_BITS)
    ) u_buf (
        .clock(clock),
        .rst_b(rst_b),
        .clear(buf_clear),
        .wr_en(spm_go && cmd_r == CMD_LOAD),
        .wr_idx(z_addr[WORD_BITS:1]),
        .wr_data(spm_data),
        .rd_idx(prog_word_idx),
        .rd_data(buf_rd),
        .any_loaded(buf_any)
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence s_armed_quiet;
        $rose(state_r == FSPS_ARMED) ##0 (!spm_exec && !lpm_exec)[*4];
    endsequence

    sequence s_start(logic [4:0] c);
        spm_go && cmd_r == c;
    endsequence

    a_erase_start: assert property (s_start(CMD_ERASE) |=> state_r == FSPS_RUN
        ##0 flash_erase_go) else $error("erase did not start");
    a_window_expiry: assert property (s_armed_quiet |=> state_r == FSPS_IDLE)
        else $error("arming window did not expire after four cycles");
    a_lpm_window: assert property ($rose(state_r == FSPS_ARMED) ##3 lpm_exec
        |-> !lpm_go) else $error("read accepted after three cycles");
    a_lock_read: assert property (lpm_go && z_addr == Z_LOCK |=> lpm_valid
        && lpm_data == {2'b11, lock_r}) else $error("lock byte read wrong");
    a_ext_fuse: assert property (lpm_go && z_addr == Z_FUSE_EXT |=> lpm_data[7:4] == 4'hF)
        else $error("extended fuse upper bits not one");
    a_irq_level: assert property (ie_r && state_r == FSPS_IDLE |=> spm_irq)
        else $error("interrupt missing while store enable clear");
    a_busy_hold: assert property (app_busy_r && !reen_go |=> app_busy_r)
        else $error("busy flag dropped without re-enable");
    a_buf_clear: assert property (prog_done && cmd_r == CMD_WRITE |=> !buf_any)
        else $error("buffer not cleared after page write");
    a_eeprom_block: assert property (eeprom_program_enable && state_r == FSPS_IDLE
        |=> state_r == FSPS_IDLE) else $error("armed during EEPROM write");
    a_halt_span: assert property (s_start(CMD_WRITE) ##0 z_page >= NCR_PAGE
        |=> cpu_halt [*8]) else $error("CPU not halted for write");
    a_lock_no_block: assert property (s_start(CMD_LOCK) ##0 !app_busy_r
        |=> !app_busy_r && !cpu_halt) else $error("lock write blocked flash");
    a_halt_section: assert property (state_r == FSPS_RUN && fsps_is_array(cmd_r)
        |-> cpu_halt == ncr_r) else $error("halt does not match target section");
endmodule
`default_nettype wire

// >>> design/fsps_pkg.sv
// Shared constants and types of the flash self-program sequencer
// Operation
// - Erase pattern then store instruction within four cycles erases the Z page.
// - Application page erase keeps other section readable; other-section erase halts CPU.
// - Load pattern plus store writes data pair into buffer word Z5:Z1.
// - Buffer clears after page write, on read re-enable write, and reset.
// - Each buffer word accepts one write until the buffer is cleared.
// - EEPROM write during page loading discards all loaded buffer words.
// - Write pattern plus store programs buffer into the Z page.
// - Application page write keeps other section readable; other-section write halts CPU.
// - With interrupt enabled, level interrupt while store enable reads cleared.
// - Application section blocked and busy flag set during erase or write.
// - Busy flag clears only when software writes the read re-enable bit.
// - Lock pattern plus store programs each lock bit whose data bit is zero.
// - Lock programming blocks no flash section for reading.
// - EEPROM write blocks self-programming and fuse or lock reads.
// - Armed lock-set read at Z 0x0001 returns lock byte within three cycles.
// - Lock-set and store enable clear on read, or on window expiry.
// - Armed read at Z 0x0000 gives low fuse, 0x0003 high fuse.
// - Armed read at Z 0x0002 gives extended fuse in bits 3 to 0.
// - Programmed bits read zero, unprogrammed bits read one.
// - Erase, write and lock programming each last 3.2 to 3.4 ms.
`default_nettype none
package fsps_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int PROG_MIN_NS = 3200000;
    localparam int PROG_MAX_NS = 3400000;
    localparam int PROG_TICKS = (PROG_MIN_NS + TICK_NS - 1) / TICK_NS;
    localparam int SPM_WINDOW = 4;
    localparam int LPM_WINDOW = 3;
    localparam int PAGE_BITS = 7;
    localparam int WORD_BITS = 5;
    localparam int PAGE_LSB = 6;
    localparam logic [PAGE_BITS-1:0] NCR_FIRST_PAGE = 7'h60;
    localparam int CSR_STORE_EN_BIT = 0;
    localparam int CSR_BUSY_BIT = 6;
    localparam int CSR_IE_BIT = 7;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_REEN = 5'h11;
    localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
    localparam logic [15:0] Z_LOCK = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam logic [5:0] LOCK_RESET = 6'h3F;
    localparam logic [7:0] READ_FILL = 8'hFF;

    typedef enum logic [1:0] {
        FSPS_IDLE = 2'b00,
        FSPS_ARMED = 2'b01,
        FSPS_RUN = 2'b11
    } fsps_state_t;

    // Operations that run on the programming timer
    function automatic logic fsps_is_timed(input logic [4:0] cmd);
        fsps_is_timed = (cmd == CMD_ERASE) || (cmd == CMD_WRITE) || (cmd == CMD_LOCK);
    endfunction

    // Operations that block the application section
    function automatic logic fsps_is_array(input logic [4:0] cmd);
        fsps_is_array = (cmd == CMD_ERASE) || (cmd == CMD_WRITE);
    endfunction
endpackage
`default_nettype wire

// >>> design/fsps_page_buffer.sv
// Temporary page buffer with write-once words
`default_nettype none
module fsps_page_buffer #(
    parameter int WORDS = 32,
    parameter int IDX_BITS = 5
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [IDX_BITS-1:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic [IDX_BITS-1:0] rd_idx,
    output logic [15:0] rd_data,
    output logic any_loaded
);
    logic [15:0] mem [WORDS];
    logic [WORDS-1:0] loaded_r;

    genvar i;
    generate
        for (i = 0; i < WORDS; i++)
        begin : g_word
            always_ff @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    loaded_r[i] <= 1'b0;
                    mem[i] <= 16'hFFFF;
                end
                else if (clear)
                begin
                    loaded_r[i] <= 1'b0;
                    mem[i] <= 16'hFFFF;
                end
                else if (wr_en && (wr_idx == IDX_BITS'(i)) && !loaded_r[i])
                begin
                    loaded_r[i] <= 1'b1;
                    mem[i] <= wr_data;
                end
            end
        end
    endgenerate

    assign rd_data = mem[rd_idx];
    assign any_loaded = |loaded_r;
endmodule
`default_nettype wire

// >>> verif/fsps_cpu_model.sv
// Core-side model issuing control writes and store or load instructions
`default_nettype none
module fsps_cpu_model (
    input wire logic clock,
    input wire logic eeprom_program_enable,
    output logic csr_wr,
    output logic [7:0] csr_wdata,
    output logic spm_exec,
    output logic lpm_exec,
    output logic [15:0] z_addr,
    output logic [15:0] spm_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        csr_wr = 1'b0;
        csr_wdata = 8'h00;
        spm_exec = 1'b0;
        lpm_exec = 1'b0;
        z_addr = 16'h0000;
        spm_data = 16'h0000;
    end
    // Control write, then store or load lag cycles later; lag 0 issues none
    task automatic op(input logic [7:0] cmd, input int lag, input logic is_lpm,
        input logic [15:0] z, input logic [15:0] d, input logic ee_ok);
        int i;
        for (i = 0; i < 100 && eeprom_program_enable && !ee_ok; i++)
            @(posedge clock);
        @(posedge clock);
        csr_wr <= 1'b1;
        csr_wdata <= cmd;
        @(posedge clock);
        csr_wr <= 1'b0;
        if (lag > 0)
        begin
            repeat (lag - 1) @(posedge clock);
            z_addr <= z;
            spm_data <= d;
            if (is_lpm)
                lpm_exec <= 1'b1;
            else
                spm_exec <= 1'b1;
            @(posedge clock);
            spm_exec <= 1'b0;
            lpm_exec <= 1'b0;
            spm_data <= ~d;
        end
    endtask
endmodule
`default_nettype wire

// >>> verif/fsps_sequencer_tb.sv
// Self-checking bench of the flash self-program sequencer
`default_nettype none
module fsps_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fsps_pkg::*;
    localparam int RUN = 4 * 5;
    logic clock;
    logic rst_b;
    logic ee;
    logic [WORD_BITS-1:0] word_idx;
    logic csr_wr;
    logic [7:0] csr_wdata;
    logic spm_exec;
    logic lpm_exec;
    logic [15:0] z_addr;
    logic [15:0] spm_data;
    logic [7:0] st;
    logic [7:0] lpm_data;
    logic lpm_valid;
    logic spm_irq;
    logic cpu_halt;
    logic busy;
    logic erase_go;
    logic write_go;
    logic [PAGE_BITS-1:0] flash_page;
    logic [15:0] prog_word;
    logic [5:0] lock_bits;
    int errors = 0;
    int n_checks = 0;
    int n_erase = 0;
    int n_write = 0;
    int n_valid = 0;
    int n_halt = 0;
    logic [23:0] rows [5] = '{24'h00005A, 24'h0001FF, 24'h0002F6, 24'h0003C3, 24'h0004FF};

    fsps_cpu_model fsps_cpu_model_inst (.clock(clock), .eeprom_program_enable(ee),
        .csr_wr(csr_wr), .csr_wdata(csr_wdata), .spm_exec(spm_exec), .lpm_exec(lpm_exec),
        .z_addr(z_addr), .spm_data(spm_data));
    fsps_sequencer #(.TICK_CYC(4), .PROG_TICK_COUNT(5)) fsps_sequencer_inst (
        .clock(clock), .rst_b(rst_b), .csr_wr(csr_wr), .csr_wdata(csr_wdata),
        .spm_exec(spm_exec), .lpm_exec(lpm_exec), .z_addr(z_addr), .spm_data(spm_data),
        .eeprom_program_enable(ee), .low_fuse_byte(8'h5A), .high_fuse_byte(8'hC3),
        .extended_fuse_byte(4'h6), .prog_word_idx(word_idx),
        .self_program_control_status(st), .lpm_data(lpm_data), .lpm_valid(lpm_valid),
        .spm_irq(spm_irq), .cpu_halt(cpu_halt), .app_section_busy(busy),
        .flash_erase_go(erase_go), .flash_write_go(write_go), .flash_page(flash_page),
        .prog_word(prog_word), .lock_bits(lock_bits));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Event counters
    always @(posedge clock)
    begin
        if (erase_go === 1'b1)
            n_erase <= n_erase + 1;
        if (write_go === 1'b1)
            n_write <= n_write + 1;
        if (lpm_valid === 1'b1)
            n_valid <= n_valid + 1;
        if (cpu_halt === 1'b1)
            n_halt <= n_halt + 1;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 500 && st[CSR_STORE_EN_BIT] !== 1'b0; i++)
            @(negedge clock);
        if (i == 500)
        begin
            errors++;
            $display("unexpected store enable: expected 0 seen 1");
            results();
        end
        repeat (2) @(negedge clock);
    endtask

    task automatic ld(input logic [4:0] idx, input logic [15:0] d);
        fsps_cpu_model_inst.op({3'h0, CMD_LOAD}, 1, 1'b0, {10'h000, idx, 1'b0}, d, 1'b0);
        repeat (2) @(negedge clock);
    endtask

    task automatic bufchk(input logic [4:0] idx, input logic [15:0] exp);
        @(posedge clock);
        word_idx <= idx;
        repeat (2) @(negedge clock);
        check("buffer word", prog_word, exp);
    endtask

    task automatic rd(input logic [15:0] z, input int lag, output logic [7:0] v,
        output int got);
        int n0;
        n0 = n_valid;
        fsps_cpu_model_inst.op({3'h0, CMD_LOCK}, lag, 1'b1, z, 16'h0000, 1'b1);
        repeat (6) @(negedge clock);
        got = n_valid - n0;
        v = lpm_data;
    endtask

    task automatic ctl(input logic [7:0] cmd);
        fsps_cpu_model_inst.op(cmd, 0, 1'b0, 16'h0000, 16'h0000, 1'b0);
        repeat (3) @(negedge clock);
    endtask

    task automatic timed(input logic [7:0] cmd, input logic [15:0] z, input logic [15:0] d,
        input logic halt, input logic bsy);
        int e0;
        int w0;
        int h0;
        e0 = n_erase;
        w0 = n_write;
        h0 = n_halt;
        fsps_cpu_model_inst.op(cmd, 1, 1'b0, z, d, 1'b0);
        repeat (3) @(negedge clock);
        check("busy run", 16'(busy), 16'(bsy));
        check("status run", 16'(st), 16'({cmd[7], bsy, 1'b0, cmd[4:1], 1'b1}));
        check("irq run", 16'(spm_irq), 16'h0000);
        wait_idle();
        check("halt cycles", 16'(n_halt - h0), halt ? 16'(RUN) : 16'h0000);
        check("erase go", 16'(n_erase - e0), 16'(cmd[4:0] == CMD_ERASE));
        check("write go", 16'(n_write - w0), 16'(cmd[4:0] == CMD_WRITE));
        if (cmd[4:0] != CMD_LOCK)
            check("page", 16'(flash_page), 16'(z[12:6]));
    endtask

    initial
    begin
        logic [7:0] v;
        int got;
        int e0;
        rst_b = 1'b0;
        ee = 1'b0;
        word_idx = '0;
        repeat (20) @(posedge clock);
        @(negedge clock);
        check("status", 16'(st), 16'(CSR_RESET));
        check("lpm data", 16'(lpm_data), 16'(READ_FILL));
        check("lock", 16'(lock_bits), 16'(LOCK_RESET));
        check("busy", 16'(busy), 16'h0000);
        @(posedge clock);
        rst_b <= 1'b1;
        done("reset");
        foreach (rows[i])
        begin
            rd(rows[i][23:8], 1, v, got);
            check("lpm valid", 16'(got), 16'h0001);
            check("lpm byte", 16'(v), 16'(rows[i][7:0]));
            check("enable after read", 16'(st[CSR_STORE_EN_BIT]), 16'h0000);
        end
        done("fuse reads");
        ld(5'h03, 16'h1234);
        ld(5'h03, 16'hABCD);
        bufchk(5'h03, 16'h1234);
        timed({3'h0, CMD_ERASE}, 16'h0140, 16'h0000, 1'b0, 1'b1);
        timed({3'h4, CMD_WRITE}, 16'h0140, 16'h0000, 1'b0, 1'b1);
        check("irq", 16'(spm_irq), 16'h0001);
        check("busy held", 16'(busy), 16'h0001);
        ld(5'h03, 16'h5555);
        bufchk(5'h03, 16'h5555);
        ld(5'h02, 16'hAAAA);
        ctl({3'h4, CMD_REEN});
        check("busy cleared", 16'(busy), 16'h0000);
        check("irq on", 16'(spm_irq), 16'h0001);
        ld(5'h02, 16'hBBBB);
        bufchk(5'h02, 16'hBBBB);
        ctl(8'h00);
        check("irq off", 16'(spm_irq), 16'h0000);
        done("app page");
        timed({3'h0, CMD_LOCK}, Z_LOCK, 16'h00F5, 1'b0, 1'b0);
        check("lock", 16'(lock_bits), 16'h0035);
        rd(Z_LOCK, 1, v, got);
        check("lock byte", 16'(v), 16'h00F5);
        timed({3'h0, CMD_ERASE}, 16'h1800, 16'h0000, 1'b1, 1'b1);
        timed({3'h0, CMD_WRITE}, 16'h1800, 16'h0000, 1'b1, 1'b1);
        ctl({3'h0, CMD_REEN});
        done("lock and halt");
        e0 = n_erase;
        fsps_cpu_model_inst.op({3'h0, CMD_ERASE}, 5, 1'b0, 16'h0140, 16'h0000, 1'b0);
        repeat (4) @(negedge clock);
        check("late erase", 16'(n_erase - e0), 16'h0000);
        check("enable expired", 16'(st[CSR_STORE_EN_BIT]), 16'h0000);
        rd(16'h0000, 4, v, got);
        check("late read", 16'(got), 16'h0000);
        done("window expiry");
        ld(5'h07, 16'h1111);
        @(posedge clock);
        ee <= 1'b1;
        e0 = n_write;
        fsps_cpu_model_inst.op({3'h0, CMD_WRITE}, 1, 1'b0, 16'h0140, 16'h0000, 1'b1);
        repeat (8) @(negedge clock);
        check("blocked write", 16'(n_write - e0), 16'h0000);
        check("blocked enable", 16'(st[CSR_STORE_EN_BIT]), 16'h0000);
        rd(16'h0000, 1, v, got);
        check("blocked read", 16'(got), 16'h0000);
        @(posedge clock);
        ee <= 1'b0;
        ld(5'h07, 16'h2222);
        bufchk(5'h07, 16'h2222);
        done("eeprom busy");
        ld(5'h09, 16'h3333);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        ld(5'h09, 16'h4444);
        bufchk(5'h09, 16'h4444);
        done("second reset");
        results();
    end
endmodule
`default_nettype wire
